//--- pkg/swx_pkg.sv
// Shared constants and types for the swap / direction / XOR execute block
package swx_pkg;

	////////////////////////////////////////////////////////////////////////
	// APB register byte offsets
	localparam logic [7:0] OFS_INSTR = 8'h00; // Instruction to execute
	localparam logic [7:0] OFS_WORK = 8'h04; // Working register
	localparam logic [7:0] OFS_STATUS = 8'h08; // Zero and ignored flags
	localparam logic [7:0] OFS_DIR5 = 8'h0c; // Direction, selector 5
	localparam logic [7:0] OFS_DIR6 = 8'h10; // Direction, selector 6
	localparam logic [7:0] OFS_DIR7 = 8'h14; // Direction, selector 7

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int DEST_BIT = 5; // Destination bit of file forms
	localparam int ZERO_BIT = 0; // Status: zero flag
	localparam int IGN_BIT = 1; // Status: ignored instruction, sticky

	////////////////////////////////////////////////////////////////////////
	// Opcode masks and match values (12-bit words)
	localparam logic [11:0] FILE_MASK = 12'hfc0;
	localparam logic [11:0] SWAP_MATCH = 12'h380; // 0011 10df ffff
	localparam logic [11:0] XORF_MATCH = 12'h180; // 0001 10df ffff
	localparam logic [11:0] DIR_MASK = 12'hff8;
	localparam logic [11:0] DIR_MATCH = 12'h000; // 0000 0000 0fff
	localparam logic [11:0] XORL_MASK = 12'hf00;
	localparam logic [11:0] XORL_MATCH = 12'hf00; // 1111 kkkk kkkk

	// Port selectors accepted by the direction load
	localparam logic [2:0] SEL_FIRST = 3'h5;
	localparam logic [2:0] SEL_SECOND = 3'h6;
	localparam logic [2:0] SEL_THIRD = 3'h7;

	////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [11:0] INSTR_RST = 12'h000;
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'hff; // All pins input

	////////////////////////////////////////////////////////////////////////
	// Decoded operation, one-hot
	typedef enum logic [4:0] {
		OP_NONE = 5'b00001,
		OP_SWAP = 5'b00010,
		OP_DIR = 5'b00100,
		OP_XORL = 5'b01000,
		OP_XORF = 5'b10000
	} swx_op_t;

	// True when the masked word equals the pattern
	function automatic logic swx_match(input logic [11:0] word,
		input logic [11:0] mask, input logic [11:0] pat);
		return (word & mask) == pat;
	endfunction : swx_match

endpackage : swx_pkg

//--- src/swx_decode.sv
// Instruction decoder for the four supported opcodes
`timescale 1ns/1ps
module swx_decode
	import swx_pkg::*;
(
	input wire logic [11:0] instr,
	output swx_op_t op,
	output logic dest,
	output logic [4:0] faddr,
	output logic [7:0] literal
);

	////////////////////////////////////////////////////////////////////////
	// Field extraction is shared by all forms
	assign dest = instr[DEST_BIT];
	assign faddr = instr[4:0];
	assign literal = instr[7:0];

	// Pattern match; out-of-range selectors fall to no operation
	always_comb begin
		op = OP_NONE;
		if (swx_match(instr, FILE_MASK, SWAP_MATCH)) begin
			op = OP_SWAP;
		end else if (swx_match(instr, FILE_MASK, XORF_MATCH)) begin
			op = OP_XORF;
		end else if (swx_match(instr, XORL_MASK, XORL_MATCH)) begin
			op = OP_XORL;
		end else if (swx_match(instr, DIR_MASK, DIR_MATCH)
			&& instr[2:0] >= SEL_FIRST) begin
			op = OP_DIR;
		end
	end

endmodule : swx_decode

//--- src/swx_alu.sv
// Result path: nibble swap and the two XOR forms
`timescale 1ns/1ps
module swx_alu
	import swx_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input swx_op_t op,
	input wire logic [WIDTH-1:0] work,
	input wire logic [WIDTH-1:0] fval,
	input wire logic [WIDTH-1:0] literal,
	output logic [WIDTH-1:0] result,
	output logic zero
);

	////////////////////////////////////////////////////////////////////////
	// Result by operation
	always_comb begin
		unique case (op)
			OP_SWAP: result = {fval[WIDTH/2-1:0],
				fval[WIDTH-1:WIDTH/2]};
			OP_XORL: result = work ^ literal;
			OP_XORF: result = work ^ fval;
			OP_DIR: result = work;
			OP_NONE: result = '0;
			default: result = '0; // Illegal one-hot code
		endcase
	end

	// Zero when every result bit is clear
	assign zero = (result == '0);

endmodule : swx_alu

//--- src/swx_exec.sv
// Swap / direction-load / XOR execute block with APB register access
// Function
// - Swap exchanges nibbles, flags kept
// - Decode swap; destination 0 writes work
// - Swap destination 1 writes file register
// - Direction load copies work, selectors 5-7
// - Direction load: one cycle, work kept
// - Literal XOR into work register
// - Literal XOR changes only zero flag
// - Decode file XOR; destination 0 writes work
// - File XOR destination 1 writes file
// - File XOR updates zero, one cycle
`timescale 1ns/1ps
module swx_exec
	import swx_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core register file
	output logic [4:0] file_addr,
	input wire logic [7:0] file_rdata,
	output logic [7:0] file_wdata,
	output logic file_we,
	// Port direction registers
	output logic [7:0] first_port_direction,
	output logic [7:0] second_port_direction,
	output logic [7:0] third_port_direction
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [11:0] instr_reg, instr_next; // Instruction being executed
	logic exec_reg, exec_next; // Execute cycle marker
	logic [31:0] prdata_reg, prdata_next; // Read data to master
	logic [7:0] work_reg, work_next; // Working register
	logic zero_reg, zero_next; // Zero flag
	logic ign_reg, ign_next; // Sticky: instruction ignored
	logic [7:0] dir5_reg, dir5_next; // Direction, selector 5
	logic [7:0] dir6_reg, dir6_next; // Direction, selector 6
	logic [7:0] dir7_reg, dir7_next; // Direction, selector 7
	logic [7:0] fwd_reg, fwd_next; // File write data
	logic fwe_reg, fwe_next; // File write strobe
	swx_op_t op; // Decoded operation
	logic dest; // Destination bit
	logic [4:0] faddr; // File address field
	logic [7:0] literal; // Literal field
	logic [7:0] alu_res; // Operation result
	logic alu_zero; // Result is zero
	logic apb_acc; // Access phase completing
	logic apb_wr; // Write completing
	logic mapped; // Address hits a register

	////////////////////////////////////////////////////////////////////////
	// Decoder and result path
	swx_decode u_decode (
		.instr(instr_reg),
		.op(op),
		.dest(dest),
		.faddr(faddr),
		.literal(literal)
	);

	swx_alu #(
		.WIDTH(8)
	) u_alu (
		.op(op),
		.work(work_reg),
		.fval(file_rdata),
		.literal(literal),
		.result(alu_res),
		.zero(alu_zero)
	);

	////////////////////////////////////////////////////////////////////////
	// APB handshake
	// Stall during the execute cycle so no bus write races the result
	assign pready = !exec_reg;
	assign apb_acc = psel && penable && pready;
	assign apb_wr = apb_acc && pwrite;

	// Address decode
	always_comb begin
		unique case (paddr)
			OFS_INSTR, OFS_WORK, OFS_STATUS,
			OFS_DIR5, OFS_DIR6, OFS_DIR7: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Unmapped addresses answer with an error, no side effect
	assign pslverr = apb_acc && !mapped;

	////////////////////////////////////////////////////////////////////////
	// Instruction capture: a write to the instruction register starts one
	// execute cycle on the next clock
	always_comb begin
		instr_next = instr_reg;
		exec_next = 1'b0;
		if (apb_wr && paddr == OFS_INSTR) begin
			instr_next = pwdata[11:0];
			exec_next = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			instr_reg <= INSTR_RST;
			exec_reg <= 1'b0;
		end else begin
			instr_reg <= instr_next;
			exec_reg <= exec_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Execution state
	always_comb begin
		work_next = work_reg;
		zero_next = zero_reg;
		ign_next = ign_reg;
		dir5_next = dir5_reg;
		dir6_next = dir6_reg;
		dir7_next = dir7_reg;
		fwd_next = fwd_reg;
		fwe_next = 1'b0;
		// Bus side: load work, clear ignored flag by writing one
		if (apb_wr && paddr == OFS_WORK) begin
			work_next = pwdata[7:0];
		end
		if (apb_wr && paddr == OFS_STATUS && pwdata[IGN_BIT]) begin
			ign_next = 1'b0;
		end
		// Execute comes after so a new set beats the clear
		if (exec_reg) begin
			unique case (op)
				OP_SWAP: begin
					// Status untouched
					if (dest) begin
						fwe_next = 1'b1;
						fwd_next = alu_res;
					end else begin
						work_next = alu_res;
					end
				end
				OP_XORF: begin
					zero_next = alu_zero;
					if (dest) begin
						fwe_next = 1'b1;
						fwd_next = alu_res;
					end else begin
						work_next = alu_res;
					end
				end
				OP_XORL: begin
					work_next = alu_res;
					zero_next = alu_zero;
				end
				OP_DIR: begin
					// Work and status keep their values
					unique case (instr_reg[2:0])
						SEL_FIRST: dir5_next = work_reg;
						SEL_SECOND: dir6_next = work_reg;
						default: dir7_next = work_reg;
					endcase
				end
				OP_NONE: ign_next = 1'b1; // Unknown word is a no-op
				default: ign_next = 1'b1; // Illegal one-hot code
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			work_reg <= WORK_RST;
			zero_reg <= 1'b0;
			ign_reg <= 1'b0;
			dir5_reg <= DIR_RST;
			dir6_reg <= DIR_RST;
			dir7_reg <= DIR_RST;
			fwd_reg <= WORK_RST;
			fwe_reg <= 1'b0;
		end else begin
			work_reg <= work_next;
			zero_reg <= zero_next;
			ign_reg <= ign_next;
			dir5_reg <= dir5_next;
			dir6_reg <= dir6_next;
			dir7_reg <= dir7_next;
			fwd_reg <= fwd_next;
			fwe_reg <= fwe_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data: built from next values so it is never a cycle stale
	always_comb begin
		prdata_next = prdata_reg;
		if (psel) begin
			unique case (paddr)
				OFS_INSTR: prdata_next = {20'h00000, instr_next};
				OFS_WORK: prdata_next = {24'h000000, work_next};
				OFS_STATUS: prdata_next = {30'h00000000, ign_next,
					zero_next};
				OFS_DIR5: prdata_next = {24'h000000, dir5_next};
				OFS_DIR6: prdata_next = {24'h000000, dir6_next};
				OFS_DIR7: prdata_next = {24'h000000, dir7_next};
				default: prdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			prdata_reg <= 32'h00000000;
		end else begin
			prdata_reg <= prdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign prdata = prdata_reg;
	assign file_addr = faddr; // From the instruction flop
	assign file_wdata = fwd_reg;
	assign file_we = fwe_reg;
	assign first_port_direction = dir5_reg;
	assign second_port_direction = dir6_reg;
	assign third_port_direction = dir7_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	// Reference values computed apart from the result path
	logic [7:0] chk_swap; // Swapped file value
	logic [7:0] chk_xorf; // Work XOR file
	logic [7:0] chk_xorl; // Work XOR literal
	assign chk_swap = {file_rdata[3:0], file_rdata[7:4]};
	assign chk_xorf = work_reg ^ file_rdata;
	assign chk_xorl = work_reg ^ instr_reg[7:0];

	a_swap_work: assert property (
		exec_reg && op == OP_SWAP && !dest
		|=> work_reg == $past(chk_swap) && !file_we)
		else $error("swap to work wrong");
	a_swap_file: assert property (
		exec_reg && op == OP_SWAP && dest
		|=> file_we && file_wdata == $past(chk_swap)
		&& $stable(work_reg))
		else $error("swap to file wrong");
	a_swap_flags: assert property (
		exec_reg && op == OP_SWAP |=> $stable(zero_reg))
		else $error("swap changed status");
	a_dir_load: assert property (
		exec_reg && op == OP_DIR && instr_reg[2:0] == SEL_SECOND
		|=> second_port_direction == $past(work_reg)
		&& $stable(first_port_direction)
		&& $stable(third_port_direction))
		else $error("direction load wrong");
	a_dir_keeps: assert property (
		exec_reg && op == OP_DIR
		|=> $stable(work_reg) && $stable(zero_reg) && !file_we)
		else $error("direction load disturbed state");
	a_xorl_work: assert property (
		exec_reg && op == OP_XORL |=> work_reg == $past(chk_xorl))
		else $error("literal xor wrong");
	a_xorl_zero: assert property (
		exec_reg && op == OP_XORL
		|=> zero_reg == ($past(chk_xorl) == 8'h00) && !file_we)
		else $error("literal xor zero wrong");
	a_xorf_work: assert property (
		exec_reg && op == OP_XORF && !dest
		|=> work_reg == $past(chk_xorf))
		else $error("file xor to work wrong");
	a_xorf_file: assert property (
		exec_reg && op == OP_XORF && dest
		|=> file_we && file_wdata == $past(chk_xorf)
		&& $stable(work_reg))
		else $error("file xor to file wrong");
	a_xorf_zero: assert property (
		exec_reg && op == OP_XORF
		|=> zero_reg == ($past(chk_xorf) == 8'h00))
		else $error("file xor zero wrong");
	a_one_cycle: assert property (
		exec_reg |=> !exec_reg && pready ##1 !file_we)
		else $error("execute longer than one cycle");
	a_zero_flag: assert property (
		exec_reg && (op == OP_XORF || op == OP_XORL)
		|=> zero_reg == $past(alu_zero)
		&& (zero_reg == (($past(alu_res)) == 8'h00)))
		else $error("zero flag mismatch");

	c_swap_file: cover property (exec_reg && op == OP_SWAP && dest);
	c_dir_load: cover property (exec_reg && op == OP_DIR);
	c_xorl_zero: cover property (exec_reg && op == OP_XORL && alu_zero);
	c_xorf_work: cover property (exec_reg && op == OP_XORF && !dest);

endmodule : swx_exec

//--- verification/swx_file_model.sv
// Behavioural model of the core register file behind the execute block
`timescale 1ns/1ps
module swx_file_model (
	input wire logic mclk,
	input wire logic [4:0] file_addr,
	output logic [7:0] file_rdata,
	input wire logic [7:0] file_wdata,
	input wire logic file_we
);
	logic [7:0] mem [32]; // File contents, seeded by the bench

	////////////////////////////////////////////////////////////////////////
	// Read is combinational: the block samples it at its execute edge
	assign file_rdata = mem[file_addr];

	// Write only on the pulse; a stuck pulse would show as a corrupt file
	always @(posedge mclk) begin
		if (file_we === 1'b1) begin
			mem[file_addr] <= file_wdata;
		end
	end

	// Backdoor load, used between transfers only
	task automatic load(input logic [4:0] a, input logic [7:0] d);
		mem[a] = d;
	endtask : load
endmodule : swx_file_model

//--- verification/swx_exec_test.sv
// Self-checking bench for the swap / direction / XOR execute block
`timescale 1ns/1ps
module swx_exec_test;
	import swx_pkg::*;
	logic mclk = 1'b0; // 40 MHz clock
	logic resetn = 1'b0; // Synchronous reset, active low
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [4:0] file_addr;
	logic [7:0] file_rdata;
	logic [7:0] file_wdata;
	logic file_we;
	int n_errors = 0; // Mismatches
	int n_checks = 0; // Comparisons made
	int cycles = 0; // Run length guard
	logic [31:0] q; // Last read data
	logic e; // Last error response
	// One ordinary case: instruction and inputs beside expected results
	typedef struct {
		logic [11:0] ins;
		logic [7:0] w;
		logic [7:0] fv;
		logic [7:0] ew;
		logic ez;
		logic [7:0] ef;
	} swx_row_t;
	// Rows run in order; the zero flag carries over from row to row
	swx_row_t rows [10] = '{
		'{12'hf5a, 8'h5a, 8'h11, 8'h00, 1'b1, 8'h11},
		'{12'h383, 8'h11, 8'ha5, 8'h5a, 1'b1, 8'ha5},
		'{12'h184, 8'hb5, 8'haf, 8'h1a, 1'b0, 8'haf},
		'{12'h1bf, 8'hb5, 8'haf, 8'hb5, 1'b0, 8'h1a},
		'{12'h3a2, 8'h00, 8'hc3, 8'h00, 1'b0, 8'h3c},
		'{12'h1a6, 8'h3c, 8'h3c, 8'h3c, 1'b1, 8'h00},
		'{12'h005, 8'ha5, 8'h77, 8'ha5, 1'b1, 8'h77},
		'{12'h006, 8'h0f, 8'h66, 8'h0f, 1'b1, 8'h66},
		'{12'h007, 8'hf0, 8'h55, 8'hf0, 1'b1, 8'h55},
		'{12'hff0, 8'h0f, 8'h44, 8'hff, 1'b0, 8'h44}
	};

	////////////////////////////////////////////////////////////////////////
	// Clock, half period 12.5 ns
	always #12.5 mclk = ~mclk;

	swx_exec DUT (
		.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.file_addr(file_addr), .file_rdata(file_rdata),
		.file_wdata(file_wdata), .file_we(file_we),
		.first_port_direction(), .second_port_direction(),
		.third_port_direction()
	);

	swx_file_model u_file (
		.mclk(mclk), .file_addr(file_addr), .file_rdata(file_rdata),
		.file_wdata(file_wdata), .file_we(file_we)
	);

	////////////////////////////////////////////////////////////////////////
	// Verdict, the only place the run ends
	task automatic give_verdict();
		if (n_errors == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict

	// Compare a data word
	task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_data

	// Compare an error response
	task automatic cmp_resp(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_resp

	// One APB transfer; pready is looked at half a cycle before the edge
	// that samples it, so no race with the flops behind it
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(negedge mclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		@(posedge mclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Read all three direction registers against expected values
	task automatic chk_dirs(input logic [23:0] exp);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, OFS_DIR5 + 8'(4 * i), 32'h0);
			cmp_data(q, {24'h0, exp[23 - 8 * i -: 8]});
		end
	endtask : chk_dirs

	// Cut a hang short
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		chk_dirs(24'hffffff);
		apb(1'b0, OFS_WORK, 32'h0);
		cmp_data(q, 32'h0);
		// Ordinary cases
		foreach (rows[i]) begin
			u_file.load(rows[i].ins[4:0], rows[i].fv);
			apb(1'b1, OFS_WORK, {24'h0, rows[i].w});
			apb(1'b1, OFS_INSTR, {20'h0, rows[i].ins});
			apb(1'b0, OFS_WORK, 32'h0);
			cmp_data(q, {24'h0, rows[i].ew});
			apb(1'b0, OFS_STATUS, 32'h0);
			cmp_data(q, {31'h0, rows[i].ez});
			cmp_data({24'h0, u_file.mem[rows[i].ins[4:0]]},
				{24'h0, rows[i].ef});
		end
		chk_dirs(24'ha50ff0);
		// Selector 4 is refused: directions stay put and the ignored flag is set
		apb(1'b1, OFS_WORK, 32'h33);
		apb(1'b1, OFS_INSTR, 32'h004);
		chk_dirs(24'ha50ff0);
		apb(1'b0, OFS_STATUS, 32'h0);
		cmp_data(q, 32'h2);
		apb(1'b1, OFS_STATUS, 32'h2);
		apb(1'b0, OFS_STATUS, 32'h0);
		cmp_data(q, 32'h0);
		// Direction registers are read-only from the bus
		apb(1'b1, OFS_DIR5, 32'h11);
		chk_dirs(24'ha50ff0);
		// Unmapped address answers with an error and no data
		apb(1'b0, 8'h18, 32'h0);
		cmp_resp(e, 1'b1);
		cmp_data(q, 32'h0);
		// Second reset in mid-run restores the start state
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		chk_dirs(24'hffffff);
		apb(1'b0, OFS_WORK, 32'h0);
		cmp_data(q, 32'h0);
		give_verdict();
	end
endmodule : swx_exec_test
